// ---- mem_cmd_defs.vh ----
// constants for the sdram command and address mapping block
`ifndef MEM_CMD_DEFS_VH
`define MEM_CMD_DEFS_VH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_REFRESH     8'h00
`define OFS_CONFIG      8'h04
`define OFS_CONFIG_TWO  8'h08
`define OFS_TIMING      8'h0C
`define OFS_ADDR        8'h10
`define OFS_WDATA       8'h14
`define OFS_CTRL        8'h18
`define OFS_STATUS      8'h1C

// ****************************************
// field positions
// ****************************************
`define CFG_BANK_MSB    1
`define CFG_BANK_LSB    0
`define CFG_COL_MSB     3
`define CFG_COL_LSB     2
`define CFG_BANKPOS     4
`define CFG_CL_MSB      7
`define CFG_CL_LSB      5
`define CFG_MDDR        8
`define TIM_RCD_MSB     3
`define TIM_RCD_LSB     0
`define TIM_RP_MSB      7
`define TIM_RP_LSB      4
`define TIM_RFC_MSB     15
`define TIM_RFC_LSB     8
`define CTRL_GO         0
`define CTRL_WRITE      1
`define CTRL_SEL_MSB    3
`define CTRL_SEL_LSB    2

// ****************************************
// reset values
// ****************************************
`define RST_REFRESH     16'h0400
`define RST_CONFIG      9'h063
`define RST_CONFIG_TWO  3'h5
`define RST_TIMING      16'h1A33

// ****************************************
// commands {cs_n, ras_n, cas_n, we_n}
// ****************************************
`define CMD_NOP         4'h7
`define CMD_ACT         4'h3
`define CMD_PRE         4'h2
`define CMD_RD          4'h5
`define CMD_WR          4'h4
`define CMD_REF         4'h1
`define CMD_MRS         4'h0

// ****************************************
// mode register content and timing counts
// ****************************************
`define MR_BURST8       3'h3
`define BA_MODE         3'h0
`define BA_EXT_MODE     3'h1
`define EMR_VALUE       14'h0000
`define T_MRD           8'h02
`define T_WR            8'h02
`define BURST_MEM_CYC   8'h04
`define BURST_BEATS     5'h08
`define SYNC_CYC        5'h04

`endif

// ---- addr_map.v ----
// logical address to bank, row and column translation
`timescale 1ns/1ps
module addr_map (
	// request address and mapping fields
	input  wire [31:0] addr_in,
	input  wire [1:0]  bank_cnt_in,
	input  wire [1:0]  col_w_in,
	input  wire [2:0]  row_w_in,
	input  wire        bank_pos_in,
	// translated address
	output reg  [2:0]  bank_out,
	output reg  [13:0] row_out,
	output reg  [10:0] col_out
);
	reg [30:0] word_a;
	reg [30:0] rest;
	reg [3:0]  ncb;
	reg [3:0]  nrb;
	reg [2:0]  bmask;
	reg [13:0] rmask;
	reg [30:0] above_row;

	// bit 0 is the byte in the halfword and takes no part
	always @* begin
		word_a = addr_in[31:1];
		ncb = 4'h8 + {2'h0, col_w_in};
		nrb = (row_w_in > 3'h5) ? 4'hE : (4'h9 + {1'h0, row_w_in});
		bmask = (3'h1 << bank_cnt_in) - 3'h1;
		rmask = (14'h1 << nrb) - 14'h1;
		col_out = word_a[10:0] & ((11'h1 << ncb) - 11'h1);
		rest = word_a >> ncb;
		above_row = rest >> nrb;
		if (bank_pos_in) begin
			row_out = rest[13:0] & rmask;
			bank_out = above_row[2:0] & bmask;
		end else begin
			bank_out = rest[2:0] & bmask;
			above_row = rest >> bank_cnt_in;
			row_out = above_row[13:0];
		end
	end

endmodule

// ---- mem_cmd_ctrl.v ----
// sdram command sequencer with register access over wishbone
//
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "mem_cmd_defs.vh"

module mem_cmd_ctrl (
	// system
	input  wire        sys_clk_in,
	input  wire        sys_rst_in,
	// wishbone slave
	input  wire        wb_cyc_in,
	input  wire        wb_stb_in,
	input  wire        wb_we_in,
	input  wire [7:0]  wb_adr_in,
	input  wire [3:0]  wb_sel_in,
	input  wire [31:0] wb_dat_in,
	output reg  [31:0] wb_dat_out,
	output reg         wb_ack_out,
	// sdram clock and command
	output reg         ddr_clk_out,
	output reg         ddr_clk_n_out,
	output reg         ddr_cke_out,
	output reg         ddr_cs_n_out,
	output reg         ddr_ras_n_out,
	output reg         ddr_cas_n_out,
	output reg         ddr_we_n_out,
	output reg  [2:0]  ddr_ba_out,
	output reg  [13:0] ddr_a_out,
	// sdram data
	output reg  [1:0]  ddr_dm_out,
	input  wire [15:0] ddr_dq_in,
	output reg  [15:0] ddr_dq_out,
	output reg         ddr_dq_oe_out,
	input  wire [1:0]  ddr_dqs_in,
	output reg  [1:0]  ddr_dqs_out,
	output reg         ddr_dqs_oe_out
);

	// ****************************************
	// states
	// ****************************************
	localparam [3:0] S_INIT_PRE = 4'h0;
	localparam [3:0] S_MRS      = 4'h1;
	localparam [3:0] S_EXT_MODE_REG_SET_CMD     = 4'h2;
	localparam [3:0] S_FIN_PRE  = 4'h3;
	localparam [3:0] S_IDLE     = 4'h4;
	localparam [3:0] S_REF_PRE  = 4'h5;
	localparam [3:0] S_REF      = 4'h6;
	localparam [3:0] S_ACC      = 4'h7;
	localparam [3:0] S_CLOSE    = 4'h8;
	localparam [3:0] S_OPEN     = 4'h9;
	localparam [3:0] S_XFER     = 4'hA;
	localparam [3:0] S_WAIT     = 4'hB;
	localparam [3:0] S_DONE     = 4'hC;

	// ****************************************
	// registers and state
	// ****************************************
	reg [15:0] refresh_q;
	reg [8:0]  config_q;
	reg [2:0]  config_two_q;
	reg [15:0] timing_q;
	reg [31:0] acc_addr_q;
	reg [15:0] acc_wdata_q;
	reg        acc_write_q;
	reg [1:0]  acc_sel_q;
	reg        busy_q;
	reg        init_done_q;
	reg [15:0] rdata_q;
	reg [3:0]  state_q;
	reg [3:0]  ret_q;
	reg [7:0]  wait_q;
	reg [15:0] ref_cnt_q;
	reg        ref_pend_q;
	reg [4:0]  rd_cnt_q;
	reg [4:0]  wr_cnt_q;
	reg [15:0] dq_meta_q;
	reg [15:0] dq_sync_q;
	reg [7:0]  pg_valid_q;
	reg [13:0] pg_row_q [0:7];

	wire [2:0]  map_bank;
	wire [13:0] map_row;
	wire [10:0] map_col;
	wire        mem_edge = ddr_clk_out;
	wire        wb_req = wb_cyc_in & wb_stb_in;
	wire        wb_wr = wb_req & wb_we_in & wb_ack_out;
	wire [2:0]  cl = config_q[`CFG_CL_MSB:`CFG_CL_LSB];
	wire [2:0]  wl = config_q[`CFG_MDDR] ? 3'h1 : (cl - 3'h1);
	wire        page_hit = pg_valid_q[map_bank] && (pg_row_q[map_bank] == map_row);
	wire [31:0] bmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
	wire [31:0] wdat = wb_dat_in & bmask;
	reg  [31:0] rd_mux;

	// page table actions, taken on the memory edge of the issuing state
	wire pg_clr_all = mem_edge && ((state_q == S_INIT_PRE) || (state_q == S_FIN_PRE) ||
		(state_q == S_REF_PRE) || (state_q == S_REF));
	wire pg_open = mem_edge && (state_q == S_OPEN);
	wire pg_close = mem_edge && (state_q == S_CLOSE);
	wire ref_tick = mem_edge && (ref_cnt_q == 16'h0000);

	// ****************************************
	// address translation
	// ****************************************
	addr_map u_map (
		.addr_in     (acc_addr_q),
		.bank_cnt_in (config_q[`CFG_BANK_MSB:`CFG_BANK_LSB]),
		.col_w_in    (config_q[`CFG_COL_MSB:`CFG_COL_LSB]),
		.row_w_in    (config_two_q),
		.bank_pos_in (config_q[`CFG_BANKPOS]),
		.bank_out    (map_bank),
		.row_out     (map_row),
		.col_out     (map_col)
	);

	// ****************************************
	// wishbone slave
	// ****************************************

	// read multiplexer, unmapped offsets read zero
	always @* begin
		case (wb_adr_in)
			`OFS_REFRESH:    rd_mux = {16'h0000, refresh_q};
			`OFS_CONFIG:     rd_mux = {23'h000000, config_q};
			`OFS_CONFIG_TWO: rd_mux = {29'h00000000, config_two_q};
			`OFS_TIMING:     rd_mux = {16'h0000, timing_q};
			`OFS_ADDR:       rd_mux = acc_addr_q;
			`OFS_WDATA:      rd_mux = {16'h0000, acc_wdata_q};
			`OFS_CTRL:       rd_mux = {28'h0000000, acc_sel_q, acc_write_q, busy_q};
			`OFS_STATUS:     rd_mux = {rdata_q, pg_valid_q, 6'h00, init_done_q, busy_q};
			default:         rd_mux = 32'h00000000;
		endcase
	end

	// single cycle ack, dropped in the following cycle
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h00000000;
		end else begin
			wb_ack_out <= wb_req & ~wb_ack_out;
			if (wb_req & ~wb_ack_out)
				wb_dat_out <= rd_mux;
		end
	end

	// software registers; writes land on the edge that carries ack
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			refresh_q <= `RST_REFRESH;
			config_q <= `RST_CONFIG;
			config_two_q <= `RST_CONFIG_TWO;
			timing_q <= `RST_TIMING;
			acc_addr_q <= 32'h00000000;
			acc_wdata_q <= 16'h0000;
			acc_write_q <= 1'b0;
			acc_sel_q <= 2'h3;
			busy_q <= 1'b0;
		end else begin
			if (wb_wr) begin
				case (wb_adr_in)
					`OFS_REFRESH:    refresh_q <= (refresh_q & ~bmask[15:0]) | wdat[15:0];
					`OFS_CONFIG:     config_q <= (config_q & ~bmask[8:0]) | wdat[8:0];
					`OFS_CONFIG_TWO: config_two_q <= (config_two_q & ~bmask[2:0]) | wdat[2:0];
					`OFS_TIMING:     timing_q <= (timing_q & ~bmask[15:0]) | wdat[15:0];
					`OFS_ADDR:       acc_addr_q <= (acc_addr_q & ~bmask) | wdat;
					`OFS_WDATA:      acc_wdata_q <= (acc_wdata_q & ~bmask[15:0]) | wdat[15:0];
					default:         ;
				endcase
			end
			// a start while busy is ignored
			if (wb_wr && wb_adr_in == `OFS_CTRL && wb_sel_in[0] && !busy_q) begin
				acc_write_q <= wb_dat_in[`CTRL_WRITE];
				acc_sel_q <= wb_dat_in[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
				if (wb_dat_in[`CTRL_GO])
					busy_q <= 1'b1;
			end else if (mem_edge && state_q == S_DONE) begin
				busy_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// memory clock divider and refresh timer
	// ****************************************

	// memory clock at half the system rate; commands change as it falls
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			ddr_clk_out <= 1'b0;
			ddr_clk_n_out <= 1'b1;
			ddr_cke_out <= 1'b0;
		end else begin
			ddr_clk_out <= ~ddr_clk_out;
			ddr_clk_n_out <= ddr_clk_out;
			ddr_cke_out <= 1'b1;
		end
	end

	// interval counter runs always; the pending flag sets over its clear
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			ref_cnt_q <= `RST_REFRESH;
			ref_pend_q <= 1'b0;
		end else begin
			if (ref_tick)
				ref_cnt_q <= refresh_q;
			else if (mem_edge)
				ref_cnt_q <= ref_cnt_q - 16'h0001;
			if (ref_tick)
				ref_pend_q <= 1'b1;
			else if (mem_edge && state_q == S_REF)
				ref_pend_q <= 1'b0;
		end
	end

	// ****************************************
	// open page table, one entry per bank
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_page
			always @(posedge sys_clk_in) begin
				if (sys_rst_in) begin
					pg_valid_q[gi] <= 1'b0;
					pg_row_q[gi] <= 14'h0000;
				end else if (pg_clr_all) begin
					pg_valid_q[gi] <= 1'b0;
				end else if (pg_open && map_bank == gi) begin
					pg_valid_q[gi] <= 1'b1;
					pg_row_q[gi] <= map_row;
				end else if (pg_close && map_bank == gi) begin
					pg_valid_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// ****************************************
	// command sequencer, steps on memory edges
	// ****************************************
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			state_q <= S_INIT_PRE;
			ret_q <= S_IDLE;
			wait_q <= 8'h00;
			init_done_q <= 1'b0;
			{ddr_cs_n_out, ddr_ras_n_out, ddr_cas_n_out, ddr_we_n_out} <= `CMD_NOP;
			ddr_ba_out <= 3'h0;
			ddr_a_out <= 14'h0000;
		end else if (mem_edge) begin
			{ddr_cs_n_out, ddr_ras_n_out, ddr_cas_n_out, ddr_we_n_out} <= `CMD_NOP;
			case (state_q)
				S_INIT_PRE, S_FIN_PRE, S_REF_PRE: begin
					// precharge every bank
					{ddr_cs_n_out, ddr_ras_n_out, ddr_cas_n_out, ddr_we_n_out} <= `CMD_PRE;
					ddr_a_out <= 14'h0400;
					wait_q <= {4'h0, timing_q[`TIM_RP_MSB:`TIM_RP_LSB]};
					state_q <= S_WAIT;
					if (state_q == S_INIT_PRE)
						ret_q <= S_MRS;
					else if (state_q == S_REF_PRE)
						ret_q <= S_REF;
					else
						ret_q <= S_IDLE;
					if (state_q == S_FIN_PRE)
						init_done_q <= 1'b1;
				end
				S_MRS: begin
					// mode register: burst eight, cas latency, no additive latency
					{ddr_cs_n_out, ddr_ras_n_out, ddr_cas_n_out, ddr_we_n_out} <= `CMD_MRS;
					ddr_ba_out <= `BA_MODE;
					ddr_a_out <= {7'h00, cl, 1'b0, `MR_BURST8};
					wait_q <= `T_MRD;
					ret_q <= S_EXT_MODE_REG_SET_CMD;
					state_q <= S_WAIT;
				end
				S_EXT_MODE_REG_SET_CMD: begin
					{ddr_cs_n_out, ddr_ras_n_out, ddr_cas_n_out, ddr_we_n_out} <= `CMD_MRS;
					ddr_ba_out <= `BA_EXT_MODE;
					ddr_a_out <= `EMR_VALUE;
					wait_q <= `T_MRD;
					ret_q <= S_FIN_PRE;
					state_q <= S_WAIT;
				end
				S_IDLE: begin
					if (ref_pend_q)
						state_q <= S_REF_PRE;
					else if (busy_q)
						state_q <= S_ACC;
				end
				S_REF: begin
					{ddr_cs_n_out, ddr_ras_n_out, ddr_cas_n_out, ddr_we_n_out} <= `CMD_REF;
					wait_q <= timing_q[`TIM_RFC_MSB:`TIM_RFC_LSB];
					ret_q <= S_IDLE;
					state_q <= S_WAIT;
				end
				S_ACC: begin
					// hit goes straight on, a miss closes an open row first
					if (ref_pend_q)
						state_q <= S_REF_PRE;
					else if (page_hit)
						state_q <= S_XFER;
					else if (pg_valid_q[map_bank])
						state_q <= S_CLOSE;
					else
						state_q <= S_OPEN;
				end
				S_CLOSE: begin
					{ddr_cs_n_out, ddr_ras_n_out, ddr_cas_n_out, ddr_we_n_out} <= `CMD_PRE;
					ddr_ba_out <= map_bank;
					ddr_a_out <= 14'h0000;
					wait_q <= {4'h0, timing_q[`TIM_RP_MSB:`TIM_RP_LSB]};
					ret_q <= S_OPEN;
					state_q <= S_WAIT;
				end
				S_OPEN: begin
					{ddr_cs_n_out, ddr_ras_n_out, ddr_cas_n_out, ddr_we_n_out} <= `CMD_ACT;
					ddr_ba_out <= map_bank;
					ddr_a_out <= map_row;
					wait_q <= {4'h0, timing_q[`TIM_RCD_MSB:`TIM_RCD_LSB]};
					ret_q <= S_XFER;
					state_q <= S_WAIT;
				end
				S_XFER: begin
					// column command; the burst runs out before the next step
					if (acc_write_q) begin
						{ddr_cs_n_out, ddr_ras_n_out, ddr_cas_n_out, ddr_we_n_out} <= `CMD_WR;
						wait_q <= {5'h00, wl} + `BURST_MEM_CYC + `T_WR;
					end else begin
						{ddr_cs_n_out, ddr_ras_n_out, ddr_cas_n_out, ddr_we_n_out} <= `CMD_RD;
						wait_q <= {5'h00, cl} + `BURST_MEM_CYC + 8'h02;
					end
					ddr_ba_out <= map_bank;
					ddr_a_out <= {2'h0, map_col[10], 1'b0, map_col[9:0]} & 14'h3BFF;
					ret_q <= S_DONE;
					state_q <= S_WAIT;
				end
				S_WAIT: begin
					if (wait_q <= 8'h01)
						state_q <= ret_q;
					else
						wait_q <= wait_q - 8'h01;
				end
				S_DONE: begin
					state_q <= S_IDLE;
				end
				default: begin
					state_q <= S_INIT_PRE;
				end
			endcase
		end
	end

	// ****************************************
	// data path
	// ****************************************

	// read data pins pass two flip-flops before use
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			dq_meta_q <= 16'h0000;
			dq_sync_q <= 16'h0000;
		end else begin
			dq_meta_q <= ddr_dq_in;
			dq_sync_q <= dq_meta_q;
		end
	end

	// first beat of a read burst is kept, the other seven dropped
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			rd_cnt_q <= 5'h00;
			rdata_q <= 16'h0000;
		end else begin
			if (mem_edge && state_q == S_XFER && !acc_write_q)
				rd_cnt_q <= {1'b0, cl, 1'b0} + `SYNC_CYC;
			else if (rd_cnt_q != 5'h00)
				rd_cnt_q <= rd_cnt_q - 5'h01;
			if (rd_cnt_q == 5'h01)
				rdata_q <= dq_sync_q;
		end
	end

	// write burst of eight beats after the write latency
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			wr_cnt_q <= 5'h00;
			ddr_dq_out <= 16'h0000;
			ddr_dq_oe_out <= 1'b0;
			ddr_dqs_out <= 2'h0;
			ddr_dqs_oe_out <= 1'b0;
			ddr_dm_out <= 2'h3;
		end else begin
			if (mem_edge && state_q == S_XFER && acc_write_q)
				wr_cnt_q <= {1'b0, wl, 1'b0} + `BURST_BEATS + 5'h01;
			else if (wr_cnt_q != 5'h00)
				wr_cnt_q <= wr_cnt_q - 5'h01;
			ddr_dq_oe_out <= (wr_cnt_q != 5'h00) && (wr_cnt_q <= `BURST_BEATS);
			ddr_dqs_oe_out <= (wr_cnt_q != 5'h00) && (wr_cnt_q <= `BURST_BEATS);
			ddr_dqs_out <= {2{wr_cnt_q[0]}};
			ddr_dq_out <= (wr_cnt_q == `BURST_BEATS) ? acc_wdata_q : 16'h0000;
			if (wr_cnt_q == `BURST_BEATS)
				ddr_dm_out <= ~acc_sel_q;
			else
				ddr_dm_out <= 2'h3;
		end
	end

endmodule

// ---- mem_cmd_ctrl_properties.sv ----
// concurrent checks on the sdram command and write data outputs
`timescale 1ns/1ps
`include "mem_cmd_defs.vh"
module mem_cmd_props (
	// system
	input wire        sys_clk_in,
	input wire        sys_rst_in,
	// sdram command
	input wire        ddr_cs_n_out,
	input wire        ddr_ras_n_out,
	input wire        ddr_cas_n_out,
	input wire        ddr_we_n_out,
	input wire [2:0]  ddr_ba_out,
	input wire [13:0] ddr_a_out,
	// sdram write data
	input wire [1:0]  ddr_dm_out,
	input wire        ddr_dq_oe_out
);
	wire [3:0] cmd;
	wire       new_cmd;
	reg  [3:0] prev_q;
	reg  [4:0] last_q;
	reg  [7:0] open_q;
	reg  [3:0] gap_q;
	reg  [1:0] mrs_q;
	// command word and its first cycle
	assign cmd = {ddr_cs_n_out, ddr_ras_n_out, ddr_cas_n_out, ddr_we_n_out};
	assign new_cmd = (cmd != `CMD_NOP) && (prev_q == `CMD_NOP);
	// last command, open banks, spacing, mode set count
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			prev_q <= `CMD_NOP;
			last_q <= 5'h1F;
			open_q <= 8'h00;
			gap_q  <= 4'hF;
			mrs_q  <= 2'h0;
		end else begin
			prev_q <= cmd;
			gap_q  <= new_cmd ? 4'h0 : ((gap_q == 4'hF) ? gap_q : gap_q + 4'h1);
			if (new_cmd) begin
				last_q <= {cmd, ddr_a_out[10]};
				if (cmd == `CMD_ACT)
					open_q[ddr_ba_out] <= 1'b1;
				if (cmd == `CMD_PRE)
					open_q <= ddr_a_out[10] ? 8'h00 : (open_q & ~(8'h01 << ddr_ba_out));
				if ((cmd == `CMD_MRS) && (mrs_q != 2'h3))
					mrs_q <= mrs_q + 2'h1;
			end
		end
	end
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (sys_rst_in);
	sequence s_new(logic [3:0] c);
		new_cmd && (cmd == c);
	endsequence
	sequence s_rd_hold;
		(cmd == `CMD_RD) && $stable(ddr_ba_out) && $stable(ddr_a_out) ##1 (cmd == `CMD_NOP);
	endsequence
	sequence s_wr_beats;
		ddr_dq_oe_out [*8] ##1 !ddr_dq_oe_out;
	endsequence
	sequence s_masked;
		(ddr_dm_out == 2'b11) [*7];
	endsequence
	property p_reset_pre;
		new_cmd && (last_q == 5'h1F) |-> (cmd == `CMD_PRE) && ddr_a_out[10];
	endproperty
	a_reset_pre: assert property (p_reset_pre) else $error("no precharge all after reset");
	property p_ref_pre;
		s_new(`CMD_REF) |-> (last_q == {`CMD_PRE, 1'b1});
	endproperty
	a_ref_pre: assert property (p_ref_pre) else $error("refresh without precharge all");
	property p_mrs_count;
		s_new(`CMD_MRS) |-> (mrs_q < 2'h2);
	endproperty
	a_mrs_count: assert property (p_mrs_count) else $error("mode set outside init");
	property p_mrs_value;
		s_new(`CMD_MRS) |-> ((ddr_ba_out == `BA_MODE) && (ddr_a_out[2:0] == `MR_BURST8) && (ddr_a_out[6:4] >= 3'h2)
			&& (ddr_a_out[6:4] <= 3'h5)) || ((ddr_ba_out == `BA_EXT_MODE) && (ddr_a_out == `EMR_VALUE));
	endproperty
	a_mrs_value: assert property (p_mrs_value) else $error("bad mode set value");
	property p_gap;
		new_cmd |-> (gap_q >= 4'h3);
	endproperty
	a_gap: assert property (p_gap) else $error("commands too close");
	property p_access_open;
		new_cmd && ((cmd == `CMD_RD) || (cmd == `CMD_WR)) |-> open_q[ddr_ba_out];
	endproperty
	a_access_open: assert property (p_access_open) else $error("access to closed bank");
	property p_act_closed;
		s_new(`CMD_ACT) |-> !open_q[ddr_ba_out];
	endproperty
	a_act_closed: assert property (p_act_closed) else $error("second page opened in bank");
	property p_rd_hold;
		s_new(`CMD_RD) |-> !ddr_a_out[10] ##1 s_rd_hold;
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read command malformed");
	property p_wr_beats;
		$rose(ddr_dq_oe_out) |-> s_wr_beats;
	endproperty
	a_wr_beats: assert property (p_wr_beats) else $error("write burst not eight beats");
	property p_wr_masked;
		$rose(ddr_dq_oe_out) |=> s_masked;
	endproperty
	a_wr_masked: assert property (p_wr_masked) else $error("surplus beats not masked");
endmodule

bind mem_cmd_ctrl mem_cmd_props u_props (
	.sys_clk_in    (sys_clk_in),
	.sys_rst_in    (sys_rst_in),
	.ddr_cs_n_out  (ddr_cs_n_out),
	.ddr_ras_n_out (ddr_ras_n_out),
	.ddr_cas_n_out (ddr_cas_n_out),
	.ddr_we_n_out  (ddr_we_n_out),
	.ddr_ba_out    (ddr_ba_out),
	.ddr_a_out     (ddr_a_out),
	.ddr_dm_out    (ddr_dm_out),
	.ddr_dq_oe_out (ddr_dq_oe_out)
);

// ---- sdram_model.sv ----
// behavioural sdram: keeps written halfwords, answers read bursts
`timescale 1ns/1ps
`include "mem_cmd_defs.vh"
module sdram_model (
	// clock and command
	input  wire        clk_in,
	input  wire        cke_in,
	input  wire        cs_n_in,
	input  wire        ras_n_in,
	input  wire        cas_n_in,
	input  wire        we_n_in,
	input  wire [2:0]  ba_in,
	input  wire [13:0] a_in,
	// data
	input  wire [1:0]  dm_in,
	input  wire [15:0] dq_in,
	input  wire        dq_oe_in,
	output reg  [15:0] dq_out,
	output reg  [1:0]  dqs_out
);
	logic [15:0] mem [logic [27:0]];
	reg   [13:0] row_q [0:7];
	reg   [27:0] key_q;
	reg   [15:0] rd_q;
	reg   [15:0] old;
	reg   [2:0]  cl_q;
	reg          wr_pend_q;
	integer      beat_q;
	wire  [3:0]  cmd;
	assign cmd = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
	// idle state
	initial begin
		dq_out    = 16'h0000;
		dqs_out   = 2'b00;
		cl_q      = 3'h3;
		wr_pend_q = 1'b0;
		beat_q    = -1;
	end
	// each memory clock edge, looked at once settled
	always @(clk_in) begin
		#1;
		if (wr_pend_q && dq_oe_in) begin
			old = mem.exists(key_q) ? mem[key_q] : 16'h0000;
			mem[key_q] = {dm_in[1] ? old[15:8] : dq_in[15:8], dm_in[0] ? old[7:0] : dq_in[7:0]};
			wr_pend_q = 1'b0;
		end
		if (beat_q >= 0)
			beat_q = beat_q + 1;
		if (clk_in && cke_in) begin
			if (cmd == `CMD_ACT)
				row_q[ba_in] = a_in;
			if ((cmd == `CMD_MRS) && (ba_in == `BA_MODE))
				cl_q = a_in[6:4];
			if ((cmd == `CMD_WR) || (cmd == `CMD_RD)) begin
				key_q = {ba_in, row_q[ba_in], a_in[11], a_in[9:0]};
				wr_pend_q = (cmd == `CMD_WR);
				rd_q = mem.exists(key_q) ? mem[key_q] : 16'h0000;
				if (cmd == `CMD_RD)
					beat_q = 0;
			end
		end
		// eight beats after cas latency, else a toggling released bus
		if ((beat_q >= 2 * cl_q) && (beat_q < 2 * cl_q + 8))
			dq_out = (beat_q == 2 * cl_q) ? rd_q : ~rd_q;
		else
			dq_out = ~dq_out;
		if (beat_q >= 2 * cl_q + 8)
			beat_q = -1;
		dqs_out = ~dqs_out;
	end
endmodule

// ---- tb_mem_cmd_ctrl.sv ----
// self-checking bench for the sdram command sequencer
`timescale 1ns/1ps
`include "mem_cmd_defs.vh"
`define CHK(nm, e, g) begin compares = compares + 1; if ((g) !== (e)) begin n_fail = n_fail + 1; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_mem_cmd_ctrl;
	// stimulus and design outputs
	reg         sys_clk_in = 1'b0;
	reg         sys_rst_in = 1'b1;
	reg         wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
	reg  [7:0]  wb_adr_in = 8'h00;
	reg  [31:0] wb_dat_in = 32'h0000_0000;
	wire [31:0] wb_dat_out;
	wire        wb_ack_out, clk_p, clk_n, cke, cs_n, ras_n, cas_n, we_n, dq_oe, dqs_oe;
	wire [2:0]  ba;
	wire [13:0] a;
	wire [1:0]  dm, dqs_i, dqs_o;
	wire [15:0] dq_i, dq_o;
	// bench state
	integer     compares = 0, n_fail = 0, cyc = 0, n_act = 0, n_ref = 0, ref_t = 0, ref_gap = 0;
	integer     i, n, nr, na, ncb, nbb;
	reg  [3:0]  prev_q = `CMD_NOP;
	reg  [2:0]  act_ba, rd_ba;
	reg  [13:0] act_row, rd_a, mrs_a;
	reg  [31:0] rdat, addr, wa, e_col, e_ba, e_row;
	reg  [1:0]  bk, pg;
	always #4 sys_clk_in = ~sys_clk_in;
	mem_cmd_ctrl dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
		.wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(4'hF), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
		.wb_ack_out(wb_ack_out), .ddr_clk_out(clk_p), .ddr_clk_n_out(clk_n), .ddr_cke_out(cke), .ddr_cs_n_out(cs_n),
		.ddr_ras_n_out(ras_n), .ddr_cas_n_out(cas_n), .ddr_we_n_out(we_n), .ddr_ba_out(ba), .ddr_a_out(a),
		.ddr_dm_out(dm), .ddr_dq_in(dq_i), .ddr_dq_out(dq_o), .ddr_dq_oe_out(dq_oe), .ddr_dqs_in(dqs_i),
		.ddr_dqs_out(dqs_o), .ddr_dqs_oe_out(dqs_oe));
	sdram_model mem_dev (.clk_in(clk_p), .cke_in(cke), .cs_n_in(cs_n), .ras_n_in(ras_n), .cas_n_in(cas_n),
		.we_n_in(we_n), .ba_in(ba), .a_in(a), .dm_in(dm), .dq_in(dq_o), .dq_oe_in(dq_oe), .dq_out(dq_i),
		.dqs_out(dqs_i));
	// command monitor and run timeout
	always @(posedge sys_clk_in) begin
		cyc = cyc + 1;
		prev_q <= {cs_n, ras_n, cas_n, we_n};
		if (({cs_n, ras_n, cas_n, we_n} != `CMD_NOP) && (prev_q == `CMD_NOP)) begin
			case ({cs_n, ras_n, cas_n, we_n})
				`CMD_ACT: begin n_act = n_act + 1; act_ba = ba; act_row = a; end
				`CMD_RD: begin rd_ba = ba; rd_a = a; end
				`CMD_REF: begin n_ref = n_ref + 1; ref_gap = cyc - ref_t; ref_t = cyc; end
				`CMD_MRS: if (ba == `BA_MODE) mrs_a = a;
				default: ;
			endcase
		end
		if (cyc == 20000) begin
			n_fail = n_fail + 1;
			final_report;
		end
	end
	// one classic wishbone cycle, held until ack is sampled
	task wb_cycle(input we, input [7:0] adr, input [31:0] dat, output [31:0] rd);
		integer k;
		begin
			@(posedge sys_clk_in);
			wb_cyc_in <= 1'b1;
			wb_stb_in <= 1'b1;
			wb_we_in  <= we;
			wb_adr_in <= adr;
			wb_dat_in <= dat;
			k = 0;
			@(posedge sys_clk_in);
			while ((wb_ack_out !== 1'b1) && (k < 50)) begin @(posedge sys_clk_in); k = k + 1; end
			rd = wb_dat_out;
			`CHK("wb ack", 1'b1, wb_ack_out)
			wb_cyc_in <= 1'b0;
			wb_stb_in <= 1'b0;
		end
	endtask
	// poll a status bit until it reaches a value
	task wait_stat(input integer b, input v);
		begin
			n = 0;
			rdat = {32{~v}};
			while ((rdat[b] !== v) && (n < 200)) begin wb_cycle(1'b0, `OFS_STATUS, 32'h0, rdat); n = n + 1; end
			`CHK("status bit", v, rdat[b])
		end
	endtask
	// one memory access through the address, data and control registers
	task mem_op(input [31:0] ad, input we, input [1:0] lanes, input [15:0] d);
		begin
			wb_cycle(1'b1, `OFS_ADDR, ad, rdat);
			wb_cycle(1'b1, `OFS_WDATA, {16'h0000, d}, rdat);
			wb_cycle(1'b1, `OFS_CTRL, {28'h0, lanes, we, 1'b1}, rdat);
			wait_stat(0, 1'b0);
		end
	endtask
	// wait for the next refresh command
	task wait_ref;
		begin
			nr = n_ref;
			n = 0;
			while ((n_ref == nr) && (n < 1000)) begin @(posedge sys_clk_in); n = n + 1; end
			`CHK("refresh seen", 1'b1, n_ref != nr)
		end
	endtask
	// verdict
	task final_report;
		begin
			$display("compares %0d n_fail %0d", compares, n_fail);
			if ((n_fail == 0) && (compares > 0))
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	// test sequence
	initial begin
		repeat (4) @(posedge sys_clk_in);
		sys_rst_in <= 1'b0;
		wb_cycle(1'b0, `OFS_REFRESH, 32'h0, rdat);
		`CHK("refresh reg", {16'h0000, `RST_REFRESH}, rdat)
		wb_cycle(1'b0, `OFS_CONFIG, 32'h0, rdat);
		`CHK("config reg", {23'h0, `RST_CONFIG}, rdat)
		wb_cycle(1'b0, `OFS_CONFIG_TWO, 32'h0, rdat);
		`CHK("config two reg", {29'h0, `RST_CONFIG_TWO}, rdat)
		wb_cycle(1'b0, `OFS_TIMING, 32'h0, rdat);
		`CHK("timing reg", {16'h0000, `RST_TIMING}, rdat)
		wb_cycle(1'b1, 8'hF0, 32'hFFFF_FFFF, rdat);
		wb_cycle(1'b0, 8'hF0, 32'h0, rdat);
		`CHK("unmapped", 32'h0000_0000, rdat)
		wait_stat(1, 1'b1);
		`CHK("mode cas latency", 3'h3, mrs_a[6:4])
		$display("test registers and init done");
		wb_cycle(1'b1, `OFS_REFRESH, 32'h0000_0040, rdat);
		for (i = 0; i < 16; i = i + 1) begin
			bk = i[1:0];
			pg = i[3:2];
			wb_cycle(1'b1, `OFS_CONFIG, {23'h0, 1'b0, 3'h3, 1'b0, pg, bk}, rdat);
			addr = 32'h0A5C_3B76 ^ (i << 17);
			mem_op(addr, 1'b0, 2'b00, 16'h0000);
			ncb = 8 + pg;
			nbb = bk;
			wa = addr >> 1;
			e_col = wa & ((32'h1 << ncb) - 32'h1);
			e_ba = (wa >> ncb) & ((32'h1 << nbb) - 32'h1);
			e_row = wa >> (ncb + nbb);
			`CHK("act row", e_row[13:0], act_row)
			`CHK("act bank", e_ba[2:0], act_ba)
			`CHK("read bank", e_ba[2:0], rd_ba)
			`CHK("read column", e_col[9:0], rd_a[9:0])
		end
		wb_cycle(1'b1, `OFS_CONFIG_TWO, 32'h0, rdat);
		wb_cycle(1'b1, `OFS_CONFIG, 32'h0000_0073, rdat);
		mem_op(32'h0025_3456, 1'b0, 2'b00, 16'h0000);
		`CHK("special row", 14'h009A, act_row)
		`CHK("special bank", 3'h1, act_ba)
		`CHK("special column", 10'h02B, rd_a[9:0])
		$display("test address mapping done");
		wb_cycle(1'b1, `OFS_CONFIG, {23'h0, `RST_CONFIG}, rdat);
		addr = 32'h0000_1234;
		mem_op(addr, 1'b1, 2'b11, 16'hA55A);
		mem_op(addr, 1'b0, 2'b00, 16'h0000);
		`CHK("read back", 16'hA55A, rdat[31:16])
		mem_op(addr, 1'b1, 2'b01, 16'h12C3);
		mem_op(addr, 1'b0, 2'b00, 16'h0000);
		`CHK("low lane write", 16'hA5C3, rdat[31:16])
		$display("test write and read done");
		wb_cycle(1'b1, `OFS_REFRESH, 32'h0000_0080, rdat);
		wait_ref;
		wait_ref;
		wait_ref;
		`CHK("refresh gap", 1'b1, (ref_gap >= 240) && (ref_gap <= 280))
		wait_ref;
		mem_op(addr, 1'b0, 2'b00, 16'h0000);
		na = n_act;
		mem_op(addr, 1'b0, 2'b00, 16'h0000);
		`CHK("open page hit", na, n_act)
		wait_ref;
		mem_op(addr, 1'b0, 2'b00, 16'h0000);
		`CHK("miss after refresh", na + 1, n_act)
		`CHK("data after refresh", 16'hA5C3, rdat[31:16])
		$display("test refresh and pages done");
		final_report;
	end
endmodule
